// ==== prs_regs.sv ====
// Pixel rate meter, link status summary and pin zero setup registers.
// Assumes a synchronous 8-bit register port and inputs synchronous to
// core_clk; the pixel clock arrives as a sampled level.
`timescale 1ns/100ps
`default_nettype none
`include "prs_defs.svh"

module prs_regs #(
  parameter logic [3:0] REVISION = 4'h9  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  // Register port
  input  wire prs_pkg::prs_bus_req_t     bus_req,
  output logic [7:0]                     bus_rdata,
  // Timing references and link state
  input  wire logic                      pix_clk_level,
  input  wire prs_pkg::prs_link_sts_t    link_sts,
  // Pin control
  input  wire logic                      second_port_select,
  input  wire prs_pkg::prs_global_pin_t  global_pin,
  input  wire logic [1:0]                func_out,
  input  wire logic [1:0]                far_value,
  output logic [1:0]                     pin_out,
  output logic [1:0]                     pin_oe_n,
  // Other state
  output logic [7:0]                     pins_one_two_cfg,
  output logic                           meter_busy
);

  // ****************************************************************
  // Constants and helpers
  // ****************************************************************
  localparam logic [`PRS_OSC_CNT_W-1:0] osc_last =
    `PRS_OSC_CNT_W'(`PRS_OSC_CYCLES - 1);

  prs_pkg::prs_state_t s_q;
  prs_pkg::prs_state_t s_d;
  logic                edge_seen;
  logic                lock_all;
  logic                wr_meter;
  logic                wr_pin;
  logic [7:0]          status_byte;
  logic [1:0]          drv0;
  logic [1:0]          drv1;

  // Returns {oe_n, out} for one pin
  function automatic logic [1:0] pin_drive(
    input prs_pkg::prs_pin_cfg_t    c,
    input prs_pkg::prs_global_pin_t g,
    input logic                     func_v,
    input logic                     far_v
  );
    logic [1:0] code;
    logic       v;
    logic [1:0] res;
    code = {c.pin_zero_direction, c.pin_zero_function_select};
    v    = c.pin_zero_local_value;
    // Global code only applies while the pin itself is left functional
    if (code == `PRS_MODE_FUNC &&
        {g.dir, g.en} != `PRS_MODE_FUNC) begin
      code = {g.dir, g.en};
      v    = g.val;
    end
    unique case (code)
      `PRS_MODE_FUNC: res = {1'b0, func_v};
      `PRS_MODE_OUT:  res = {1'b0, v};
      `PRS_MODE_TRI,
      `PRS_MODE_IN:   res = {1'b1, 1'b0};
    endcase
    if (c.pin_zero_far_control) begin
      res = {1'b0, far_v};
    end
    return res;
  endfunction

  assign edge_seen = pix_clk_level ^ s_q.pix_prev;
  assign lock_all  = link_sts.two_lane_receive_flag ?
                     (link_sts.lock_a & link_sts.lock_b) :
                     link_sts.lock_a;
  assign wr_meter  = bus_req.wr && bus_req.addr == `PRS_OFS_METER;
  assign wr_pin    = bus_req.wr && bus_req.addr == `PRS_OFS_PIN_ZERO;
  assign drv0      = pin_drive(s_q.pin_cfg[0], global_pin,
                               func_out[0], far_value[0]);
  assign drv1      = pin_drive(s_q.pin_cfg[1], global_pin,
                               func_out[1], far_value[1]);

  always_comb begin
    status_byte = 8'h00;
    status_byte[`PRS_STS_ONE]   = 1'b1;
    status_byte[`PRS_STS_DUAL]  = link_sts.two_lane_receive_flag;
    status_byte[`PRS_STS_AUDIO] = link_sts.audio_pll_lock;
    status_byte[`PRS_STS_LOCK]  = lock_all;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d          = s_q;
    s_d.pix_prev = pix_clk_level;

    // Window timing; the oscillator tick is a divided enable
    if (s_q.win_on) begin
      if (edge_seen && s_q.tally != `PRS_TALLY_MAX) begin
        s_d.tally = s_q.tally + 8'h01;
      end
      if (s_q.osc_cnt == osc_last) begin
        s_d.osc_cnt  = '0;
        s_d.per_left = s_q.per_left - 8'h01;
        if (s_q.per_left == 8'h01) begin
          s_d.win_on = 1'b0;
        end
      end else begin
        s_d.osc_cnt = s_q.osc_cnt + `PRS_OSC_CNT_W'(1);
      end
    end

    // A write restarts the window even if one is running
    if (wr_meter) begin
      s_d.tally    = `PRS_RST_METER;
      s_d.osc_cnt  = '0;
      s_d.per_left = bus_req.wdata;
      s_d.win_on   = bus_req.wdata != 8'h00;
    end

    if (wr_pin) begin
      s_d.pin_cfg[second_port_select] = bus_req.wdata[3:0];
    end
    if (bus_req.wr && bus_req.addr == `PRS_OFS_PINS_12) begin
      s_d.pins12 = bus_req.wdata;
    end

    // Read data valid only in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `PRS_OFS_METER:    s_d.rdata = s_q.tally;
        `PRS_OFS_STATUS:   s_d.rdata = status_byte;
        `PRS_OFS_PIN_ZERO: begin
          s_d.rdata = {REVISION, s_q.pin_cfg[second_port_select]};
        end
        `PRS_OFS_PINS_12:  s_d.rdata = s_q.pins12;
        default:           s_d.rdata = 8'h00;
      endcase
    end

    s_d.pin_out  = {drv1[0], drv0[0]};
    s_d.pin_oe_n = {drv1[1], drv0[1]};
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q          <= '0;
      s_q.tally    <= `PRS_RST_METER;
      s_q.pins12   <= `PRS_RST_PINS_12;
      s_q.pin_cfg  <= {`PRS_RST_PIN_CFG, `PRS_RST_PIN_CFG};
      s_q.pin_oe_n <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata        = s_q.rdata;
  assign pin_out          = s_q.pin_out;
  assign pin_oe_n         = s_q.pin_oe_n;
  assign pins_one_two_cfg = s_q.pins12;
  assign meter_busy       = s_q.win_on;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Helper: length and elapsed cycles of the current window
  logic [7:0]  chk_len_q;
  logic [11:0] chk_cyc_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_len_q <= 8'h00;
      chk_cyc_q <= 12'h000;
    end else if (wr_meter) begin
      chk_len_q <= bus_req.wdata;
      chk_cyc_q <= 12'h000;
    end else if (s_q.win_on) begin
      chk_cyc_q <= chk_cyc_q + 12'h001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence meter_write_s;
    wr_meter && bus_req.wdata != 8'h00;
  endsequence

  sequence window_open_s;
    s_q.win_on && s_q.tally == 8'h00;
  endsequence

  a_meter_write_start: assert property (
    meter_write_s |=> window_open_s)
    else $error("Meter write did not open a window");

  a_window_length_exact: assert property (
    $fell(s_q.win_on) && !$past(wr_meter) |->
      chk_cyc_q == 12'(chk_len_q) * 12'(`PRS_OSC_CYCLES))
    else $error("Window length differs from value times period");

  a_meter_read_tally: assert property (
    bus_req.rd && bus_req.addr == `PRS_OFS_METER |=>
      bus_rdata == $past(s_q.tally))
    else $error("Meter read is not the tally");

  a_tally_holds_max: assert property (
    s_q.tally == `PRS_TALLY_MAX && !wr_meter |=>
      s_q.tally == `PRS_TALLY_MAX)
    else $error("Tally wrapped past maximum");

  a_tally_counts_edge: assert property (
    s_q.win_on && edge_seen && !wr_meter &&
      s_q.tally != `PRS_TALLY_MAX |=>
      s_q.tally == $past(s_q.tally) + 8'h01)
    else $error("Edge in window not counted");

  a_idle_no_count: assert property (
    !s_q.win_on && !wr_meter |=> $stable(s_q.tally))
    else $error("Tally moved outside a window");

  a_status_dual_bit: assert property (
    bus_req.rd && bus_req.addr == `PRS_OFS_STATUS |=>
      bus_rdata[`PRS_STS_DUAL] == $past(link_sts.two_lane_receive_flag))
    else $error("Dual mode status bit wrong");

  a_status_audio_bit: assert property (
    bus_req.rd && bus_req.addr == `PRS_OFS_STATUS |=>
      bus_rdata[`PRS_STS_AUDIO] == $past(link_sts.audio_pll_lock))
    else $error("Audio lock status bit wrong");

  a_status_lock_bit: assert property (
    bus_req.rd && bus_req.addr == `PRS_OFS_STATUS &&
      link_sts.two_lane_receive_flag && !link_sts.lock_b |=>
      !bus_rdata[`PRS_STS_LOCK])
    else $error("Lock reported with one lane unlocked");

  a_port_select_write: assert property (
    wr_pin && second_port_select |=>
      s_q.pin_cfg[1] == $past(bus_req.wdata[3:0]) &&
      $stable(s_q.pin_cfg[0]))
    else $error("Second port write reached wrong pin");

  a_local_value_drive: assert property (
    !s_q.pin_cfg[0].pin_zero_far_control &&
      {s_q.pin_cfg[0].pin_zero_direction,
       s_q.pin_cfg[0].pin_zero_function_select} == `PRS_MODE_OUT |=>
      !pin_oe_n[0] &&
      pin_out[0] == $past(s_q.pin_cfg[0].pin_zero_local_value))
    else $error("Local value not driven in output mode");

  a_far_value_drive: assert property (
    s_q.pin_cfg[0].pin_zero_far_control |=>
      !pin_oe_n[0] && pin_out[0] == $past(far_value[0]))
    else $error("Remote value not driven");

  a_tristate_release: assert property (
    !s_q.pin_cfg[0].pin_zero_far_control &&
      s_q.pin_cfg[0].pin_zero_direction |=> pin_oe_n[0])
    else $error("Pin driven in tri-state or input mode");

  a_revision_field: assert property (
    bus_req.rd && bus_req.addr == `PRS_OFS_PIN_ZERO |=>
      bus_rdata[7:`PRS_REV_LSB] == REVISION)
    else $error("Revision nibble wrong");

  a_pin_over_global: assert property (
    s_q.pin_cfg[0] == 4'h2 |=> pin_oe_n[0])
    else $error("Global setting overrode pin setting");

  a_tally_cleared: assert property (
    wr_meter |=> s_q.tally == 8'h00)
    else $error("Meter write did not clear tally");

  a_status_fixed_one: assert property (
    bus_req.rd && bus_req.addr == `PRS_OFS_STATUS |=>
      bus_rdata[`PRS_STS_ONE] && bus_rdata[7:6] == 2'b00)
    else $error("Status reserved bits wrong");

  a_single_lane_lock: assert property (
    bus_req.rd && bus_req.addr == `PRS_OFS_STATUS &&
      !link_sts.two_lane_receive_flag |=>
      bus_rdata[`PRS_STS_LOCK] == $past(link_sts.lock_a))
    else $error("Single lane lock bit wrong");

  a_dual_lane_lock: assert property (
    bus_req.rd && bus_req.addr == `PRS_OFS_STATUS &&
      link_sts.two_lane_receive_flag && link_sts.lock_a &&
      link_sts.lock_b |=> bus_rdata[`PRS_STS_LOCK])
    else $error("Lock missing with both lanes locked");

  a_window_bounded: assert property (
    s_q.win_on |->
      chk_cyc_q < 12'(chk_len_q) * 12'(`PRS_OSC_CYCLES))
    else $error("Window ran past value times period");

  a_zero_write_idle: assert property (
    wr_meter && bus_req.wdata == 8'h00 |=> !meter_busy)
    else $error("Zero length window left meter busy");

  a_function_mode_drive: assert property (
    s_q.pin_cfg[0] == 4'h0 &&
      {global_pin.dir, global_pin.en} == `PRS_MODE_FUNC |=>
      !pin_oe_n[0] && pin_out[0] == $past(func_out[0]))
    else $error("Functional output not driven");

  a_global_out_drive: assert property (
    s_q.pin_cfg[0] == 4'h0 &&
      {global_pin.dir, global_pin.en} == `PRS_MODE_OUT |=>
      !pin_oe_n[0] && pin_out[0] == $past(global_pin.val))
    else $error("Global value not driven on functional pin");

  a_primary_pin_write: assert property (
    wr_pin && !second_port_select |=>
      s_q.pin_cfg[0] == $past(bus_req.wdata[3:0]) &&
      $stable(s_q.pin_cfg[1]))
    else $error("Primary port write reached wrong pin");

endmodule // prs_regs
`default_nettype wire

// ==== prs_defs.svh ====
// Constants of the pixel rate meter, link status and pin zero register slice.
// Assumes an 8-bit register port and a 250 MHz core clock.
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PRS_OFS_METER      8'h1b
`define PRS_OFS_STATUS     8'h1c
`define PRS_OFS_PIN_ZERO   8'h1d
`define PRS_OFS_PINS_12    8'h1e

// ****************************************************************
// Reset values and tally limit
// ****************************************************************
`define PRS_RST_METER      8'h00
`define PRS_RST_PINS_12    8'h00
`define PRS_RST_PIN_CFG    4'h0
`define PRS_TALLY_MAX      8'hff

// ****************************************************************
// Field positions
// ****************************************************************
`define PRS_STS_LOCK       0
`define PRS_STS_AUDIO      3
`define PRS_STS_DUAL       4
`define PRS_STS_ONE        5
`define PRS_REV_LSB        4

// Pin mode codes, {direction, function select}
`define PRS_MODE_FUNC      2'h0
`define PRS_MODE_OUT       2'h1
`define PRS_MODE_TRI       2'h2
`define PRS_MODE_IN        2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define PRS_CLK_PERIOD_NS  4
`define PRS_OSC_PERIOD_NS  40
`define PRS_OSC_CYCLES \
  ((`PRS_OSC_PERIOD_NS + `PRS_CLK_PERIOD_NS - 1) / `PRS_CLK_PERIOD_NS)
`define PRS_OSC_CNT_W      4

`endif

// ==== prs_pkg.sv ====
// Types shared by the pixel rate, status and pin zero register slice.
// Assumes prs_defs.svh is on the include path.
`default_nettype none
`include "prs_defs.svh"

package prs_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } prs_bus_req_t;

  typedef struct packed {
    logic lock_a;
    logic lock_b;
    logic two_lane_receive_flag;
    logic audio_pll_lock;
  } prs_link_sts_t;

  typedef struct packed {
    logic dir;
    logic en;
    logic val;
  } prs_global_pin_t;

  typedef struct packed {
    logic pin_zero_local_value;
    logic pin_zero_far_control;
    logic pin_zero_direction;
    logic pin_zero_function_select;
  } prs_pin_cfg_t;

  typedef struct packed {
    logic                        win_on;
    logic [`PRS_OSC_CNT_W-1:0]   osc_cnt;
    logic [7:0]                  per_left;
    logic [7:0]                  tally;
    logic                        pix_prev;
    prs_pin_cfg_t [1:0]          pin_cfg;
    logic [7:0]                  pins12;
    logic [7:0]                  rdata;
    logic [1:0]                  pin_out;
    logic [1:0]                  pin_oe_n;
  } prs_state_t;

endpackage
`default_nettype wire

// ==== test_prs_regs.sv ====
// Self-checking bench for the pixel rate, status and pin zero registers.
// Assumes prs_pkg and prs_defs.svh from the design are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "prs_defs.svh"

module test_prs_regs;
  // ****************************************************************
  // Signals
  // ****************************************************************
  typedef struct packed {
    logic [3:0] cfg;
    logic [2:0] glob;
    logic       far;
    logic       func;
    logic       oe_n;
    logic       out;
  } prs_tb_row_t;

  localparam logic [3:0] REV = 4'h5;  // Arbitrary value

  logic                     core_clk = 1'b0;
  logic                     arst_n   = 1'b0;
  prs_pkg::prs_bus_req_t    req      = '0;
  prs_pkg::prs_link_sts_t   link     = '0;
  prs_pkg::prs_global_pin_t glob     = '0;
  logic                     pix      = 1'b0;
  logic                     sel      = 1'b0;
  logic [1:0]               func     = 2'h0;
  logic [1:0]               far      = 2'h0;
  logic [7:0]               rdata;
  logic [1:0]               pin_out;
  logic [1:0]               pin_oe_n;
  logic [7:0]               pins12;
  logic                     busy;
  logic [7:0]               d;
  logic [7:0]               e;
  int                       len;
  int                       fail_count = 0;
  int                       checked    = 0;
  prs_tb_row_t              rows [12] = '{
    '{4'h0, 3'h0, 1'b0, 1'b1, 1'b0, 1'b1},
    '{4'h2, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0},
    '{4'h1, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0},
    '{4'h9, 3'h0, 1'b1, 1'b0, 1'b0, 1'b1},
    '{4'h3, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0},
    '{4'hb, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0},
    '{4'h4, 3'h0, 1'b1, 1'b0, 1'b0, 1'b1},
    '{4'hf, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0},
    '{4'h0, 3'h3, 1'b0, 1'b0, 1'b0, 1'b1},
    '{4'h1, 3'h3, 1'b0, 1'b1, 1'b0, 1'b0},
    '{4'h0, 3'h4, 1'b0, 1'b1, 1'b1, 1'b0},
    '{4'h9, 3'h4, 1'b0, 1'b0, 1'b0, 1'b1}};

  always #2 core_clk = ~core_clk;

  prs_regs #(.REVISION(REV)) u_dut (
    .core_clk         (core_clk),
    .arst_n           (arst_n),
    .bus_req          (req),
    .bus_rdata        (rdata),
    .pix_clk_level    (pix),
    .link_sts         (link),
    .second_port_select(sel),
    .global_pin       (glob),
    .func_out         (func),
    .far_value        (far),
    .pin_out          (pin_out),
    .pin_oe_n         (pin_oe_n),
    .pins_one_two_cfg (pins12),
    .meter_busy       (busy)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    req.addr  <= a;
    req.wdata <= v;
    req.wr    <= 1'b1;
    @(posedge core_clk);
    req.wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge core_clk);
    req.rd   <= 1'b0;
    #1 v = rdata;
  endtask

  // Opens a window of n periods and toggles the pixel level k times in it
  task automatic meas(input logic [7:0] n, input int k);
    wr(`PRS_OFS_METER, n);
    len = 0;
    #1;
    while (busy === 1'b1 && len < 3000) begin
      @(posedge core_clk);
      if (len >= 2 && len < 2 + k) pix <= ~pix;
      len++;
      #1;
    end
  endtask

  task automatic stop_test;
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    stop_test();
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    @(posedge core_clk);
    #1 chk({6'h0, pin_oe_n}, 8'h03);
    chk({7'h0, busy}, 8'h00);
    chk(rdata, 8'h00);
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`PRS_OFS_METER, d);
    chk(d, `PRS_RST_METER);
    rd(`PRS_OFS_PINS_12, d);
    chk(d, `PRS_RST_PINS_12);
    rd(`PRS_OFS_PIN_ZERO, d);
    chk(d, {REV, 4'h0});
    // Pin mode table, global code in play only on some rows
    foreach (rows[i]) begin
      @(posedge core_clk);
      glob <= rows[i].glob;
      far  <= {1'b0, rows[i].far};
      func <= {1'b0, rows[i].func};
      wr(`PRS_OFS_PIN_ZERO, {4'h0, rows[i].cfg});
      repeat (3) @(posedge core_clk);
      #1 chk({7'h0, pin_oe_n[0]}, {7'h0, rows[i].oe_n});
      if (!rows[i].oe_n) begin
        chk({7'h0, pin_out[0]}, {7'h0, rows[i].out});
      end
    end
    // Second port redirect leaves pin zero alone
    @(posedge core_clk);
    glob <= '0;
    sel  <= 1'b1;
    wr(`PRS_OFS_PIN_ZERO, 8'hf3);
    repeat (3) @(posedge core_clk);
    #1 chk({6'h0, pin_oe_n}, 8'h02);
    chk({7'h0, pin_out[0]}, 8'h01);
    rd(`PRS_OFS_PIN_ZERO, d);
    chk(d, {REV, 4'h3});
    // Second port pin under far control
    @(posedge core_clk);
    far <= 2'h2;
    wr(`PRS_OFS_PIN_ZERO, 8'h04);
    repeat (3) @(posedge core_clk);
    #1 chk({6'h0, pin_oe_n}, 8'h00);
    chk({6'h0, pin_out}, 8'h03);
    @(posedge core_clk);
    sel <= 1'b0;
    rd(`PRS_OFS_PIN_ZERO, d);
    chk(d, {REV, 4'h9});
    // Status over every input combination, writes ignored
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      link <= i[3:0];
      wr(`PRS_OFS_STATUS, 8'hff);
      rd(`PRS_OFS_STATUS, d);
      e = {3'h1, i[1], i[0], 2'h0, i[1] ? i[3] & i[2] : i[3]};
      chk(d, e);
    end
    wr(`PRS_OFS_PINS_12, 8'ha5);
    #1 chk(pins12, 8'ha5);
    rd(`PRS_OFS_PINS_12, d);
    chk(d, 8'ha5);
    @(posedge core_clk);
    #1 chk(rdata, 8'h00);
    rd(8'h40, d);
    chk(d, 8'h00);
    // Meter windows: length, tally, restart, saturation, empty window
    meas(8'h03, 7);
    chk(len[7:0], 8'd30);
    rd(`PRS_OFS_METER, d);
    chk(d, 8'h07);
    wr(`PRS_OFS_METER, 8'h02);
    repeat (3) @(posedge core_clk) pix <= ~pix;
    meas(8'h02, 4);
    chk(len[7:0], 8'd20);
    rd(`PRS_OFS_METER, d);
    chk(d, 8'h04);
    meas(8'h64, 300);
    chk(len[7:0], 8'he8);
    chk({6'h0, len[9:8]}, 8'h03);
    rd(`PRS_OFS_METER, d);
    chk(d, `PRS_TALLY_MAX);
    meas(8'h00, 0);
    chk(len[7:0], 8'h00);
    rd(`PRS_OFS_METER, d);
    chk(d, 8'h00);
    // Reset in the middle of a window
    wr(`PRS_OFS_METER, 8'h05);
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b0;
    #1 chk({7'h0, busy}, 8'h00);
    chk(pins12, 8'h00);
    chk({6'h0, pin_oe_n}, 8'h03);
    @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`PRS_OFS_PIN_ZERO, d);
    chk(d, {REV, 4'h0});
    stop_test();
  end
endmodule // test_prs_regs
`default_nettype wire
